// >>> core/lsr_defs.vh
// Constants for the link status register bank: offsets, field positions,
// reset values and self-ID error codes.
// Assumes it is included by bare name from the core modules.
`ifndef LSR_DEFS_VH
`define LSR_DEFS_VH

// Register byte offsets on the APB.
`define LSR_OFF_FIFO      8'h30
`define LSR_OFF_TOPO      8'h34
`define LSR_OFF_SELFID    8'h38

// Transmit FIFO status fields.
`define LSR_FIFO_FULL     0
`define LSR_FIFO_AFULL    1
`define LSR_FIFO_FOUR     4
`define LSR_FIFO_AEMPTY   14
`define LSR_FIFO_EMPTY    15
`define LSR_FIFO_CLR      19
`define LSR_FIFO_SIZE_LO  26
`define LSR_FIFO_SIZE_HI  31
`define LSR_FIFO_SIZE_RST 6'h00
`define LSR_FOUR_ROOM     7'h04

// Topology fields.
`define LSR_TOPO_VALID    0
`define LSR_TOPO_CNT_LO   2
`define LSR_TOPO_CNT_HI   7
`define LSR_TOPO_ROOT     8
`define LSR_TOPO_CONT     9
`define LSR_TOPO_IRM_LO   10
`define LSR_TOPO_IRM_HI   15
`define LSR_TOPO_BUS_LO   16
`define LSR_TOPO_BUS_HI   25
`define LSR_TOPO_NODE_LO  26
`define LSR_TOPO_NODE_HI  31
`define LSR_BUS_ID_RESET  10'h3FF

// Self_id_error_check fields and error codes.
`define LSR_SID_CODE_HI   3
`define LSR_SID_CLR       15
`define LSR_SID_NONE      4'h0
`define LSR_SID_NOT_CHILD 4'h1
`define LSR_SID_BAD_PHYID 4'h2
`define LSR_SID_PHASE     4'h3
`define LSR_SID_TWO_GAPS  4'h4
`define LSR_SID_BIG_GAP   4'h5
`define LSR_SID_IN_PKT    4'h6
`define LSR_SID_NOT_INV   4'h7
`define LSR_SID_FAULTY    4'h8

`endif

// >>> core/lsr_fifo_level.v
// Occupancy tracker for the transmit FIFO; derives the fill flags.
// Assumes push and pop are one-cycle strobes from the FIFO datapath.
`timescale 1ns/1ps
`include "lsr_defs.vh"

module lsr_fifo_level #(
  parameter AW = 6
) (
  // Clock and reset.
  input  wire          pclk,
  input  wire          presetn,
  // Datapath strobes and controls.
  input  wire          push,
  input  wire          pop,
  input  wire          clear,
  input  wire [AW-1:0] size,
  // Fill flags, combinational from the count.
  output wire          full,
  output wire          almost_full,
  output wire          four_free,
  output wire          almost_empty,
  output wire          empty
);

  reg  [AW-1:0] count_reg;
  wire [AW:0]   room;
  wire          push_ok;
  wire          pop_ok;

  // Free room in quadlets; a size shrunk below the count reads as no room.
  assign room = (count_reg >= size) ? {(AW+1){1'b0}} :
                ({1'b0, size} - {1'b0, count_reg});

  assign full         = (room == {(AW+1){1'b0}});  // RULE_01
  assign almost_full  = (room == {{AW{1'b0}}, 1'b1});  // RULE_02
  assign four_free    = (room >= `LSR_FOUR_ROOM);  // RULE_03
  assign almost_empty = (count_reg == {{(AW-1){1'b0}}, 1'b1});  // RULE_04
  assign empty        = (count_reg == {AW{1'b0}});  // RULE_05

  // A push while full is dropped so a push never takes the count past the size.
  assign push_ok = push & ~full;  // RULE_01
  assign pop_ok  = pop & ~empty;

  // Clear wins over traffic in the same cycle: it empties the FIFO.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {AW{1'b0}};
    end else if (clear) begin
      count_reg <= {AW{1'b0}};  // RULE_07
    end else if (push_ok && !pop_ok) begin
      count_reg <= count_reg + {{(AW-1){1'b0}}, 1'b1};
    end else if (pop_ok && !push_ok) begin
      count_reg <= count_reg - {{(AW-1){1'b0}}, 1'b1};
    end
  end

endmodule

// >>> core/lsr_regs.v
// Link status register bank: transmit FIFO status, topology after bus
// reset and self-ID error check, reached as an APB slave.
// Assumes the FIFO datapath, the phy side and the diagnostics and mode
// registers live outside and drive the strobes and levels below.
//
// How it works
// (RULE_01) Full flag in bit 0 when no room; pushes while full are dropped.
// (RULE_02) Almost-full flag in bit 1 when exactly one more write fits.
// (RULE_03) Four-free flag in bit 4 when room for four or more quadlets.
// (RULE_04) Almost-empty flag in bit 14 when exactly one quadlet stored.
// (RULE_05) Empty flag in bit 15 when no quadlet stored.
// (RULE_06) Flag bits read-only unless register-test write is enabled.
// (RULE_07) Writing one to bit 19 empties the transmit FIFO.
// (RULE_08) Size field bits 26-31 is read/write, resets to zero.
// (RULE_09) FIFO status at 30h: flags read-only, controls writable, reset zero; reads 8001h after reset here, as size zero sets full and empty.
// (RULE_10) Valid bit 0 set only while topology results are valid.
// (RULE_11) Bits 2-7 report the number of nodes detected.
// (RULE_12) Bit 8 set when this node is root.
// (RULE_13) Bit 9 shows the contender pin level.
// (RULE_14) Bits 10-15 hold the resource manager node identifier.
// (RULE_15) Bus number bits 16-25 load 3FFh at bus reset when enabled.
// (RULE_16) Node number updates after bus reset; writable only in manual mode.
// (RULE_17) Bits 0-3 keep the first self-ID error code; zero means none.
// (RULE_18) Codes 1 to 4 name child, phy ID, phase and two-gap errors.
// (RULE_19) Codes 5 to 7 name large gap, in-packet and inversion errors.
// (RULE_20) A bus reset returns the self-ID error code to zero.
// (RULE_21) Writing one to bit 15 clears the self-ID error code.
// (RULE_22) Reserved bits read zero and ignore writes.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "lsr_defs.vh"

module lsr_regs #(
  parameter AW = 6
) (
  // APB slave.
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // Transmit FIFO datapath.
  input  wire          fifo_push,
  input  wire          fifo_pop,
  input  wire          register_test_write,
  output reg           fifo_clear_reg,
  output reg           fifo_full_reg,
  output reg  [AW-1:0] fifo_size_reg,
  // Topology results from the bus-reset logic.
  input  wire          bus_reset,
  input  wire          topo_done,
  input  wire [5:0]    nodes_detected_in,
  input  wire          root_in,
  input  wire          contender_pin,
  input  wire [5:0]    resource_manager_id_in,
  input  wire [5:0]    local_node_in,
  input  wire          reset_bus_id_enable,
  input  wire          manual_override_mode,
  output reg  [9:0]    bus_id_field_reg,
  output reg  [5:0]    local_node_field_reg,
  // Self-ID checker.
  input  wire          selfid_err_valid,
  input  wire [3:0]    selfid_err_code
);

  // Bus phases.
  wire        setup_ph;
  wire        access_ph;
  wire        wr_ev;
  wire        hit_fifo;
  wire        hit_topo;
  wire        hit_sid;
  wire        hit_any;

  // Live FIFO flags from the occupancy tracker.
  wire        live_full;
  wire        live_afull;
  wire        live_four;
  wire        live_aempty;
  wire        live_empty;

  // Forced flags used while the register test write is enabled.
  reg         force_on_reg;
  reg  [4:0]  force_flags_reg;
  wire [4:0]  flags_next;
  reg  [4:0]  flags_reg;

  // Topology state.
  reg         topo_valid_reg;
  reg  [5:0]  nodes_detected_reg;
  reg         root_reg;
  reg         contender_reg;
  reg  [5:0]  resource_manager_id_reg;

  // Self-ID code and its clear strobe.
  wire [3:0]  selfid_error_code;
  wire        selfid_error_clear;

  // Per-register write strobes from a completed write.
  wire        wr_fifo;
  wire        wr_topo;
  wire        wr_sid;

  // Read words of each register, and the one the address selects.
  reg  [31:0] fifo_word;
  reg  [31:0] topo_word;
  reg  [31:0] sid_word;
  reg  [31:0] rd_next;

  // Setup samples the request; the answer comes ready in the access phase.
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & pready;
  assign wr_ev     = access_ph & pwrite;
  assign hit_fifo  = (paddr == `LSR_OFF_FIFO);
  assign hit_topo  = (paddr == `LSR_OFF_TOPO);
  assign hit_sid   = (paddr == `LSR_OFF_SELFID);
  assign hit_any   = hit_fifo | hit_topo | hit_sid;

  // An unmapped offset matches none of these, so its writes change nothing.
  assign wr_fifo   = wr_ev & hit_fifo;  // RULE_22
  assign wr_topo   = wr_ev & hit_topo;
  assign wr_sid    = wr_ev & hit_sid;

  // Clear strobes come from the write event itself, not from stored bits.
  assign selfid_error_clear = wr_sid & pwdata[`LSR_SID_CLR];  // RULE_21

  // Occupancy of the transmit FIFO, sized by the software size field.
  // A size below the current count reads as full until entries drain.
  lsr_fifo_level #(
    .AW (AW)
  ) u_level (
    .pclk         (pclk),
    .presetn      (presetn),
    .push         (fifo_push),
    .pop          (fifo_pop),
    .clear        (fifo_clear_reg),
    .size         (fifo_size_reg),
    .full         (live_full),
    .almost_full  (live_afull),
    .four_free    (live_four),
    .almost_empty (live_aempty),
    .empty        (live_empty)
  );

  // First self-ID error capture.
  // The logger arbitrates an error against a clear itself; the set wins.
  lsr_selfid_log u_sid (
    .pclk      (pclk),
    .presetn   (presetn),
    .err_valid (selfid_err_valid),
    .err_code  (selfid_err_code),
    .bus_reset (bus_reset),
    .sw_clear  (selfid_error_clear),
    .code_reg  (selfid_error_code)
  );

  // APB handshake: one wait-free access per setup. Because pready follows
  // the setup cycle alone, a setup may follow an access back to back.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ph;
    end
  end

  // Unmapped offsets are refused with an error in the same access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_ph & ~hit_any;  // RULE_22
    end
  end

  // Test access: a write to the status word pins the flags while the test
  // enable stays high; dropping the enable hands the flags back to hardware.
  // The live count keeps running underneath, so leaving test mode is safe.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_on_reg    <= 1'b0;
      force_flags_reg <= 5'h00;
    end else if (!register_test_write) begin
      force_on_reg    <= 1'b0;
    end else if (wr_fifo) begin
      force_on_reg    <= 1'b1;  // RULE_06
      force_flags_reg <= {pwdata[`LSR_FIFO_EMPTY], pwdata[`LSR_FIFO_AEMPTY],
                          pwdata[`LSR_FIFO_FOUR], pwdata[`LSR_FIFO_AFULL],
                          pwdata[`LSR_FIFO_FULL]};
    end
  end

  // Flag order inside the vector: empty, almost empty, four free,
  // almost full, full.
  assign flags_next = force_on_reg ? force_flags_reg :
                      {live_empty, live_aempty, live_four, live_afull, live_full};

  // Flags are registered so the read path and the full output are glitch free;
  // this costs one cycle of lag behind the occupancy count.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg     <= 5'h00;  // RULE_09
      fifo_full_reg <= 1'b0;
    end else begin
      flags_reg     <= flags_next;
      fifo_full_reg <= flags_next[0];  // RULE_01
    end
  end

  // FIFO clear: a one-cycle pulse; the bit itself is never stored, so it
  // reads back as zero and cannot clear the FIFO a second time.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_clear_reg <= 1'b0;
    end else begin
      fifo_clear_reg <= wr_fifo & pwdata[`LSR_FIFO_CLR];  // RULE_07
    end
  end

  // FIFO size: holds its value until software writes the status word again.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_size_reg <= `LSR_FIFO_SIZE_RST;  // RULE_08
    end else if (wr_fifo) begin
      fifo_size_reg <= pwdata[`LSR_FIFO_SIZE_HI:`LSR_FIFO_SIZE_LO];  // RULE_09
    end
  end

  // Valid flag: cleared by a bus reset until fresh results arrive; a result
  // in the same cycle as a bus reset is kept, so valid wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      topo_valid_reg <= 1'b0;
    end else if (topo_done) begin
      topo_valid_reg <= 1'b1;  // RULE_10
    end else if (bus_reset) begin
      topo_valid_reg <= 1'b0;  // RULE_10
    end
  end

  // Topology results: loaded together on the done strobe and held after a
  // bus reset, so software can still read the last results while invalid.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nodes_detected_reg      <= 6'h00;
      root_reg                <= 1'b0;
      resource_manager_id_reg <= 6'h00;
    end else if (topo_done) begin
      nodes_detected_reg      <= nodes_detected_in;  // RULE_11
      root_reg                <= root_in;  // RULE_12
      resource_manager_id_reg <= resource_manager_id_in;  // RULE_14
    end
  end

  // The contender pin is taken as a synchronous level and shown as is.
  // A pin that may change near the clock needs a synchroniser outside.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contender_reg <= 1'b0;
    end else begin
      contender_reg <= contender_pin;  // RULE_13
    end
  end

  // Bus number: software owns it, but a bus reset with the enable set
  // restores the unassigned value. The reset wins over a same-cycle write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_id_field_reg <= `LSR_BUS_ID_RESET;
    end else if (bus_reset && reset_bus_id_enable) begin
      bus_id_field_reg <= `LSR_BUS_ID_RESET;  // RULE_15
    end else if (wr_topo) begin
      bus_id_field_reg <= pwdata[`LSR_TOPO_BUS_HI:`LSR_TOPO_BUS_LO];
    end
  end

  // Node number follows the topology result; software may only overwrite it
  // in manual mode, and a fresh result still takes precedence.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_node_field_reg <= 6'h00;
    end else if (topo_done) begin
      local_node_field_reg <= local_node_in;  // RULE_16
    end else if (wr_topo && manual_override_mode) begin
      local_node_field_reg <= pwdata[`LSR_TOPO_NODE_HI:`LSR_TOPO_NODE_LO];  // RULE_16
    end
  end

  // Status word at 30h; every bit not named below reads as zero.
  always @* begin
    fifo_word = 32'h00000000;  // RULE_22
    fifo_word[`LSR_FIFO_FULL]   = flags_reg[0];  // RULE_01
    fifo_word[`LSR_FIFO_AFULL]  = flags_reg[1];  // RULE_02
    fifo_word[`LSR_FIFO_FOUR]   = flags_reg[2];  // RULE_03
    fifo_word[`LSR_FIFO_AEMPTY] = flags_reg[3];  // RULE_04
    fifo_word[`LSR_FIFO_EMPTY]  = flags_reg[4];  // RULE_05
    fifo_word[`LSR_FIFO_SIZE_HI:`LSR_FIFO_SIZE_LO] = fifo_size_reg;  // RULE_08
  end

  // Topology word at 34h; the reserved bit between the fields reads as zero.
  always @* begin
    topo_word = 32'h00000000;  // RULE_22
    topo_word[`LSR_TOPO_VALID] = topo_valid_reg;  // RULE_10
    topo_word[`LSR_TOPO_CNT_HI:`LSR_TOPO_CNT_LO] = nodes_detected_reg;  // RULE_11
    topo_word[`LSR_TOPO_ROOT]  = root_reg;  // RULE_12
    topo_word[`LSR_TOPO_CONT]  = contender_reg;  // RULE_13
    topo_word[`LSR_TOPO_IRM_HI:`LSR_TOPO_IRM_LO] = resource_manager_id_reg;  // RULE_14
    topo_word[`LSR_TOPO_BUS_HI:`LSR_TOPO_BUS_LO] = bus_id_field_reg;  // RULE_15
    topo_word[`LSR_TOPO_NODE_HI:`LSR_TOPO_NODE_LO] = local_node_field_reg;  // RULE_16
  end

  // Self-ID word at 38h; the clear bit is a strobe and reads as zero.
  always @* begin
    sid_word = 32'h00000000;  // RULE_22
    sid_word[`LSR_SID_CODE_HI:0] = selfid_error_code;  // RULE_17
  end

  // Read select; an unmapped offset reads as zero alongside its error.
  always @* begin
    case (paddr)
      `LSR_OFF_FIFO: begin
        rd_next = fifo_word;
      end
      `LSR_OFF_TOPO: begin
        rd_next = topo_word;
      end
      `LSR_OFF_SELFID: begin
        rd_next = sid_word;
      end
      default: begin
        rd_next = 32'h00000000;  // RULE_22
      end
    endcase
  end

  // Read data is captured in the setup cycle and held through the access.
  // This keeps the answer wait-free; a flag moving during the access is missed.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h00000000 : rd_next;
    end
  end

endmodule

// >>> core/lsr_selfid_log.v
// Keeps the code of the first self-ID error since the last clear.
// Assumes err_valid is a one-cycle strobe carrying err_code.
`timescale 1ns/1ps
`include "lsr_defs.vh"

module lsr_selfid_log (
  // Clock and reset.
  input  wire       pclk,
  input  wire       presetn,
  // Error reports and clears.
  input  wire       err_valid,
  input  wire [3:0] err_code,
  input  wire       bus_reset,
  input  wire       sw_clear,
  // Logged code.
  output reg  [3:0] code_reg
);

  wire code_known;

  // Codes above the faulty-quadlet code are reserved and never logged.
  assign code_known = (err_code != `LSR_SID_NONE) && (err_code <= `LSR_SID_FAULTY);

  // Only the first error is kept; a new error in the clearing cycle wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= `LSR_SID_NONE;
    end else if (err_valid && code_known &&
                 (code_reg == `LSR_SID_NONE || bus_reset || sw_clear)) begin
      code_reg <= err_code;  // RULE_17 RULE_18 RULE_19
    end else if (bus_reset) begin
      code_reg <= `LSR_SID_NONE;  // RULE_20
    end else if (sw_clear) begin
      code_reg <= `LSR_SID_NONE;  // RULE_21
    end
  end

endmodule

// >>> tb/link_status_registers_tb_top.sv
// Self-checking bench for the link status register bank.
// Assumes lsr_regs and its header are compiled alongside; size is set to 5.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end
module link_status_registers_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, fifo_clear_reg, fifo_full_reg;
  logic        fifo_push = 0, fifo_pop = 0, register_test_write = 0;
  logic        bus_reset = 0, topo_done = 0, root_in = 0, contender_pin = 0;
  logic        reset_bus_id_enable = 0, manual_override_mode = 0, selfid_err_valid = 0;
  logic [5:0]  nodes_detected_in = 0, resource_manager_id_in = 0, local_node_in = 0;
  logic [5:0]  fifo_size_reg, local_node_field_reg;
  logic [9:0]  bus_id_field_reg;
  logic [3:0]  selfid_err_code = 0;
  int          errors = 0, num_checks = 0;

  lsr_regs #(.AW(6)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fifo_push, .fifo_pop, .register_test_write,
    .fifo_clear_reg, .fifo_full_reg, .fifo_size_reg, .bus_reset, .topo_done,
    .nodes_detected_in, .root_in, .contender_pin, .resource_manager_id_in,
    .local_node_in, .reset_bus_id_enable, .manual_override_mode, .bus_id_field_reg,
    .local_node_field_reg, .selfid_err_valid, .selfid_err_code);

  // Free-running 250 MHz clock.
  always #2 pclk = ~pclk;

  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One APB transfer; the wait for pready is bounded so a dead slave ends the run.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    repeat (3) @(posedge pclk);
  endtask

  // Reads a register and compares it with the expected word.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Strobes for FIFO pushes, bus resets and self-ID errors.
  task automatic push(input int k);
    repeat (k) begin
      fifo_push <= 1;
      @(posedge pclk);
      fifo_push <= 0;
      @(posedge pclk);
    end
  endtask
  task automatic breset;
    bus_reset <= 1;
    @(posedge pclk);
    bus_reset <= 0;
    @(posedge pclk);
  endtask
  task automatic serr(input logic [3:0] c);
    selfid_err_code <= c;
    selfid_err_valid <= 1;
    @(posedge pclk);
    selfid_err_valid <= 0;
    @(posedge pclk);
  endtask

  // Values after reset, and an unmapped address.
  task automatic t_reset;
    rdchk(8'h30, 32'h00008001);
    rdchk(8'h34, 32'h03FF0000);
    rdchk(8'h38, 32'h00000000);
    apb(0, 8'h3C, 32'h0);
    `CHK({err, rd}, 33'h100000000)
  endtask

  // Fill flags across the occupancy range, drop when full, clear and test forcing.
  task automatic t_fifo;
    apb(1, 8'h30, 32'h14000000);
    rdchk(8'h30, 32'h14008010);
    push(1);
    rdchk(8'h30, 32'h14004010);
    push(1);
    rdchk(8'h30, 32'h14000000);
    push(2);
    rdchk(8'h30, 32'h14000002);
    push(1);
    rdchk(8'h30, 32'h14000001);
    `CHK(fifo_full_reg, 1'b1)
    push(1);
    fifo_pop <= 1;
    @(posedge pclk);
    fifo_pop <= 0;
    @(posedge pclk);
    rdchk(8'h30, 32'h14000002);
    apb(1, 8'h30, 32'h1400C013);
    rdchk(8'h30, 32'h14000002);
    apb(1, 8'h30, 32'h14080000);
    rdchk(8'h30, 32'h14008010);
    register_test_write <= 1;
    apb(1, 8'h30, 32'h14000013);
    rdchk(8'h30, 32'h14000013);
    register_test_write <= 0;
    repeat (2) @(posedge pclk);
    rdchk(8'h30, 32'h14008010);
  endtask

  // Topology load, read-only fields, manual node write and bus resets.
  task automatic t_topo;
    contender_pin <= 1;
    nodes_detected_in <= 6'h2A;
    root_in <= 1;
    resource_manager_id_in <= 6'h15;
    local_node_in <= 6'h33;
    topo_done <= 1;
    @(posedge pclk);
    topo_done <= 0;
    rdchk(8'h34, 32'hCFFF57A9);
    apb(1, 8'h34, 32'hFD23FFFF);
    rdchk(8'h34, 32'hCD2357A9);
    manual_override_mode <= 1;
    apb(1, 8'h34, 32'h15230000);
    rdchk(8'h34, 32'h152357A9);
    manual_override_mode <= 0;
    breset;
    rdchk(8'h34, 32'h152357A8);
    reset_bus_id_enable <= 1;
    contender_pin <= 0;
    breset;
    rdchk(8'h34, 32'h17FF55A8);
  endtask

  // Every error code, first one kept, clears by software and by bus reset.
  task automatic t_sid;
    for (int i = 1; i <= 8; i++) begin
      serr(4'(i));
      serr(4'(i % 8 + 1));
      rdchk(8'h38, 32'(i));
      apb(1, 8'h38, 32'h0000800F);
      rdchk(8'h38, 32'h0);
    end
    serr(4'h9);
    rdchk(8'h38, 32'h0);
    serr(4'h3);
    apb(1, 8'h38, 32'hFFFF7FF0);
    rdchk(8'h38, 32'h3);
    breset;
    rdchk(8'h38, 32'h0);
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_fifo;
    t_topo;
    t_sid;
    tally_and_finish;
  end
endmodule

// >>> tb/lsr_regs_chk.sv
// Assertion checker for the link status register bank.
// Assumes it is bound to lsr_regs and sees only its ports.
`timescale 1ns/1ps
module lsr_regs_chk #(
  parameter AW = 6
) (
  // APB side.
  input wire          pclk,
  input wire          presetn,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [7:0]    paddr,
  input wire [31:0]   pwdata,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  // Datapath and topology side.
  input wire          fifo_clear_reg,
  input wire [AW-1:0] fifo_size_reg,
  input wire          bus_reset,
  input wire          topo_done,
  input wire [5:0]    local_node_in,
  input wire          reset_bus_id_enable,
  input wire          manual_override_mode,
  input wire [9:0]    bus_id_field_reg,
  input wire [5:0]    local_node_field_reg
);
  // A completed write and a setup cycle, as seen on the bus.
  wire wr  = psel & penable & pready & pwrite;
  wire stp = psel & ~penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  clr_pulse_a: assert property (
    wr && paddr == 8'h30 && pwdata[19] |=> fifo_clear_reg ##1 !fifo_clear_reg)
    else $error("clear pulse wrong");
  size_write_a: assert property (
    wr && paddr == 8'h30 |=> fifo_size_reg == $past(pwdata[31:32-AW]))
    else $error("size field not written");
  bus_id_load_a: assert property (
    bus_reset && reset_bus_id_enable |=> bus_id_field_reg == 10'h3FF)
    else $error("bus number not reloaded");
  node_lock_a: assert property (
    wr && paddr == 8'h34 && !manual_override_mode && !topo_done
    |=> $stable(local_node_field_reg)) else $error("node number written");
  node_load_a: assert property (
    topo_done |=> local_node_field_reg == $past(local_node_in))
    else $error("node number not loaded");
  unmapped_err_a: assert property (
    stp && !(paddr inside {8'h30, 8'h34, 8'h38}) |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  sid_reserved_a: assert property (
    stp && !pwrite && paddr == 8'h38 |=> prdata[31:4] == 28'h0)
    else $error("self-ID reserved bits set");
  fifo_reserved_a: assert property (
    stp && !pwrite && paddr == 8'h30 |=> prdata[25:16] == 10'h0 && prdata[13:5] == 9'h0)
    else $error("status reserved bits set");
  // Main scenarios reached.
  clr_c: cover property (wr && paddr == 8'h30 && pwdata[19]);
  topo_c: cover property (topo_done);
  bres_c: cover property (bus_reset && reset_bus_id_enable);
endmodule
bind lsr_regs lsr_regs_chk #(.AW(AW)) chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_clear_reg, .fifo_size_reg,
  .bus_reset, .topo_done, .local_node_in, .reset_bus_id_enable, .manual_override_mode,
  .bus_id_field_reg, .local_node_field_reg);
